/* File: include/glcd_pkg.sv */
// constants shared by the graphic lcd command decoder
package glcd_pkg;
   localparam logic [7:0] CMD_CURSOR = 8'h21;
   localparam logic [7:0] CMD_OFFSET = 8'h22;
   localparam logic [7:0] CMD_ADDR = 8'h24;
   localparam logic [7:0] CMD_TXT_HOME = 8'h40;
   localparam logic [7:0] CMD_TXT_AREA = 8'h41;
   localparam logic [7:0] CMD_GFX_HOME = 8'h42;
   localparam logic [7:0] CMD_GFX_AREA = 8'h43;
   localparam logic [7:0] CMD_BLINK = 8'h50;
   localparam logic [7:0] CMD_AUTOMOVE = 8'h60;
   localparam logic [7:0] CMD_FONT = 8'h70;
   localparam logic [7:0] CMD_REVERSE = 8'hD0;
   localparam logic [7:0] CMD_AUTO_WR = 8'hB0;
   localparam logic [7:0] CMD_AUTO_RD = 8'hB1;
   localparam logic [7:0] CMD_AUTO_RST = 8'hB2;
   localparam logic [3:0] GRP_MODE = 4'h8;
   localparam logic [3:0] GRP_DISP = 4'h9;
   localparam logic [4:0] GRP_CURPAT = 5'h14;
   localparam logic [4:0] GRP_DATA = 5'h18;
   localparam logic [3:0] GRP_BIT = 4'hF;
   localparam int COL_BITS = 7;
   localparam int ROW_BITS = 5;
   localparam int OFS_BITS = 5;
   localparam int ADDR_BITS = 16;
   localparam logic [2:0] BLINK_RESET = 3'h2;
   localparam logic [1:0] FONT_RESET = 2'h0;
   localparam logic [2:0] COMBINE_RESET = 3'h0;
   localparam logic [2:0] CURSOR_H_RESET = 3'h0;
   localparam logic [1:0] FONT_NONE1 = 2'h1;
   localparam logic [2:0] DIR_INC = 3'h0;
   localparam logic [2:0] DIR_DEC = 3'h2;
   localparam logic [2:0] DIR_HOLD = 3'h4;
   localparam int SYNC_STAGES = 2;
endpackage

/* File: src/glcd_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module glcd_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         meta_ff <= INIT;
         q_o <= INIT;
      end else begin
         meta_ff <= d_i;
         q_o <= meta_ff;
      end
   end
endmodule

/* File: src/glcd_decoder.sv */
// command decoder of the graphic lcd controller
`timescale 1ns/10ps
module glcd_decoder
   import glcd_pkg::*;
#(
   parameter int AW = 16
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic WR_N_I,
   input wire logic RD_N_I,
   input wire logic CE_N_I,
   input wire logic CD_I,
   input wire logic [7:0] DB_I,
   output logic [7:0] DB_O,
   output logic DB_OE_O,
   input wire logic DUAL_SCAN_I,
   output logic MEM_WE_O,
   output logic MEM_RE_O,
   output logic [AW-1:0] MEM_ADDR_O,
   output logic [7:0] MEM_WDATA_O,
   input wire logic [7:0] MEM_RDATA_I,
   output logic [COL_BITS-1:0] CURSOR_COL_O,
   output logic [ROW_BITS-1:0] CURSOR_ROW_O,
   output logic CURSOR_LOWER_O,
   output logic [OFS_BITS-1:0] CG_OFFSET_O,
   output logic [15:0] TEXT_HOME_O,
   output logic [7:0] TEXT_AREA_O,
   output logic [15:0] GFX_HOME_O,
   output logic [7:0] GFX_AREA_O,
   output logic [2:0] COMBINE_MODE_O,
   output logic EXT_EXTERNAL_CHARACTER_RAM_O,
   output logic TEXT_ON_O,
   output logic GFX_ON_O,
   output logic CURSOR_ON_O,
   output logic CURSOR_BLINK_O,
   output logic [2:0] CURSOR_HEIGHT_O,
   output logic AUTO_WR_O,
   output logic AUTO_RD_O,
   output logic REVERSE_O,
   output logic [2:0] BLINK_TIME_O,
   output logic AUTO_MOVE_O,
   output logic [1:0] FONT_SEL_O
);
   // ----------------------------------------
   // pin synchronisation and strobe edges
   // ----------------------------------------
   logic [12:0] pin_s;
   logic wr_n_s, rd_n_s, ce_n_s, cd_s, dual_s;
   logic [7:0] db_s;
   logic wr_d_ff, rd_d_ff;

   glcd_sync #(.WIDTH(13), .INIT(13'h1C00)) u_sync (
      .CLK_I(CLK_I),
      .RST_I(RST_I),
      .d_i({WR_N_I, RD_N_I, CE_N_I, CD_I, DUAL_SCAN_I, DB_I}),
      .q_o(pin_s)
   );
   assign {wr_n_s, rd_n_s, ce_n_s, cd_s, dual_s, db_s} = pin_s;

   wire wr_act = ~wr_n_s & ~ce_n_s;
   wire rd_act = ~rd_n_s & ~ce_n_s;
   wire wr_rise = wr_act & ~wr_d_ff;
   wire rd_rise = rd_act & ~rd_d_ff;
   wire data_wr = wr_rise & ~cd_s;
   wire cmd_wr = wr_rise & cd_s;
   wire data_rd = rd_rise & ~cd_s;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   logic [7:0] p1_ff, p2_ff, cmd_ff;
   logic [AW-1:0] adp_ff;
   logic rd_pend_ff;
   logic [2:0] rd_dir_ff;
   logic bit_pend_ff, bit_val_ff;
   logic [2:0] bit_idx_ff;

   function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a, input logic [2:0] dir);
      step_addr = (dir == DIR_INC) ? a + 1'b1 : (dir == DIR_DEC) ? a - 1'b1 : a;
   endfunction

   wire is_mode = cmd_wr & (db_s[7:4] == GRP_MODE);
   wire is_disp = cmd_wr & (db_s[7:4] == GRP_DISP);
   wire is_curpat = cmd_wr & (db_s[7:3] == GRP_CURPAT);
   wire is_data = cmd_wr & (db_s[7:3] == GRP_DATA) & (db_s[2:1] != 2'h3);
   wire is_dwrite = is_data & ~db_s[0];
   wire is_dread = is_data & db_s[0];
   wire is_bit = cmd_wr & (db_s[7:4] == GRP_BIT);
   wire auto_wr_byte = data_wr & AUTO_WR_O;
   wire auto_rd_byte = data_rd & AUTO_RD_O;
   wire [2:0] mode_low = db_s[2:0];
   wire mode_ok = (mode_low == 3'h0) | (mode_low == 3'h1) | (mode_low == 3'h3) | (mode_low == 3'h4);
   wire font_ok = p1_ff[1];

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         wr_d_ff <= 1'b0;
         rd_d_ff <= 1'b0;
         p1_ff <= 8'h00;
         p2_ff <= 8'h00;
         cmd_ff <= 8'h00;
      end else begin
         wr_d_ff <= wr_act;
         rd_d_ff <= rd_act;
         // last two data bytes written outside auto write stand as the parameters
         if (data_wr & ~AUTO_WR_O) begin
            p1_ff <= p2_ff;
            p2_ff <= db_s;
         end
         if (cmd_wr) begin
            cmd_ff <= db_s;
         end
      end
   end

   // ----------------------------------------
   // settings registers
   // ----------------------------------------
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         CURSOR_COL_O <= '0;
         CURSOR_ROW_O <= '0;
         CG_OFFSET_O <= '0;
         TEXT_HOME_O <= 16'h0000;
         TEXT_AREA_O <= 8'h00;
         GFX_HOME_O <= 16'h0000;
         GFX_AREA_O <= 8'h00;
         COMBINE_MODE_O <= COMBINE_RESET;
         EXT_EXTERNAL_CHARACTER_RAM_O <= 1'b0;
         TEXT_ON_O <= 1'b0;
         GFX_ON_O <= 1'b0;
         CURSOR_ON_O <= 1'b0;
         CURSOR_BLINK_O <= 1'b0;
         CURSOR_HEIGHT_O <= CURSOR_H_RESET;
         REVERSE_O <= 1'b0;
         BLINK_TIME_O <= BLINK_RESET;
         AUTO_MOVE_O <= 1'b0;
         FONT_SEL_O <= FONT_RESET;
         AUTO_WR_O <= 1'b0;
         AUTO_RD_O <= 1'b0;
      end else if (cmd_wr) begin
         // parameters: p1_ff is the first, p2_ff the second
         if (db_s == CMD_CURSOR) begin
            CURSOR_COL_O <= p1_ff[COL_BITS-1:0];
            CURSOR_ROW_O <= p2_ff[ROW_BITS-1:0];
         end
         if (db_s == CMD_OFFSET) CG_OFFSET_O <= p1_ff[OFS_BITS-1:0];
         if (db_s == CMD_TXT_HOME) TEXT_HOME_O <= {p2_ff, p1_ff};
         if (db_s == CMD_TXT_AREA) TEXT_AREA_O <= p1_ff;
         if (db_s == CMD_GFX_HOME) GFX_HOME_O <= {p2_ff, p1_ff};
         if (db_s == CMD_GFX_AREA) GFX_AREA_O <= p1_ff;
         if (is_mode) begin
            if (mode_ok) COMBINE_MODE_O <= mode_low;
            EXT_EXTERNAL_CHARACTER_RAM_O <= db_s[3];
         end
         if (is_disp) begin
            TEXT_ON_O <= db_s[2];
            GFX_ON_O <= db_s[3];
            CURSOR_ON_O <= db_s[1];
            CURSOR_BLINK_O <= db_s[1] & db_s[0];
         end
         if (is_curpat) CURSOR_HEIGHT_O <= db_s[2:0];
         // second parameter ignored on option commands
         if (db_s == CMD_REVERSE) REVERSE_O <= p1_ff[0];
         if (db_s == CMD_BLINK) BLINK_TIME_O <= p1_ff[2:0];
         if (db_s == CMD_AUTOMOVE) AUTO_MOVE_O <= p1_ff[0];
         if ((db_s == CMD_FONT) & font_ok) FONT_SEL_O <= p1_ff[1:0];
         if (db_s == CMD_AUTO_WR) AUTO_WR_O <= 1'b1;
         if (db_s == CMD_AUTO_RD) AUTO_RD_O <= 1'b1;
         if (db_s == CMD_AUTO_RST) begin
            AUTO_WR_O <= 1'b0;
            AUTO_RD_O <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // display memory access
   // ----------------------------------------
   // memory read data is taken one cycle after MEM_RE_O; cursor column and row never touched here
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         adp_ff <= '0;
         CURSOR_LOWER_O <= 1'b0;
         MEM_WE_O <= 1'b0;
         MEM_RE_O <= 1'b0;
         MEM_ADDR_O <= '0;
         MEM_WDATA_O <= 8'h00;
         DB_O <= 8'h00;
         DB_OE_O <= 1'b0;
         rd_pend_ff <= 1'b0;
         rd_dir_ff <= DIR_HOLD;
         bit_pend_ff <= 1'b0;
         bit_val_ff <= 1'b0;
         bit_idx_ff <= 3'h0;
      end else begin
         MEM_WE_O <= 1'b0;
         MEM_RE_O <= 1'b0;
         rd_pend_ff <= MEM_RE_O;
         // tracks the scan strap too, so no cursor reload is needed when it changes
         CURSOR_LOWER_O <= dual_s & CURSOR_ROW_O[ROW_BITS-1];
         DB_OE_O <= rd_act;
         if (rd_rise & cd_s) begin
            // status: ready flags always set, auto flags reflect mode
            DB_O <= {4'h0, AUTO_WR_O, AUTO_RD_O, 2'h3};
         end
         if (cmd_wr & (db_s == CMD_ADDR)) begin
            adp_ff <= AW'({p2_ff, p1_ff});
         end else if (is_dwrite | auto_wr_byte) begin
            MEM_WE_O <= 1'b1;
            MEM_ADDR_O <= adp_ff;
            MEM_WDATA_O <= is_dwrite ? p2_ff : db_s;
            adp_ff <= step_addr(adp_ff, is_dwrite ? {db_s[2:1], 1'b0} : DIR_INC);
         end else if (is_dread | auto_rd_byte | is_bit) begin
            MEM_RE_O <= 1'b1;
            MEM_ADDR_O <= adp_ff;
            rd_dir_ff <= is_dread ? {db_s[2:1], 1'b0} : (is_bit ? DIR_HOLD : DIR_INC);
            bit_pend_ff <= is_bit;
            bit_val_ff <= db_s[3];
            bit_idx_ff <= db_s[2:0];
         end else if (rd_pend_ff) begin
            adp_ff <= step_addr(adp_ff, rd_dir_ff);
            if (bit_pend_ff) begin
               MEM_WE_O <= 1'b1;
               MEM_WDATA_O <= bit_val_ff ? (MEM_RDATA_I | (8'h01 << bit_idx_ff))
                                         : (MEM_RDATA_I & ~(8'h01 << bit_idx_ff));
               bit_pend_ff <= 1'b0;
            end else begin
               DB_O <= MEM_RDATA_I;
            end
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   cursor_load_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      cmd_wr && db_s == CMD_CURSOR |=> CURSOR_COL_O == $past(p1_ff[6:0]) && CURSOR_ROW_O == $past(p2_ff[4:0]))
      else $error("cursor not loaded");
   cursor_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      !(cmd_wr && db_s == CMD_CURSOR) |=> $stable(CURSOR_COL_O) && $stable(CURSOR_ROW_O))
      else $error("cursor moved");
   lower_half_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      CURSOR_LOWER_O == $past(dual_s && CURSOR_ROW_O[ROW_BITS-1]))
      else $error("lower half flag wrong");
   disp_off_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      cmd_wr && db_s == 8'h90 |=> !TEXT_ON_O && !GFX_ON_O && !CURSOR_ON_O)
      else $error("display not off");
   blink_dep_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      CURSOR_BLINK_O |-> CURSOR_ON_O)
      else $error("blink without cursor");
   write_pulse_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      is_dwrite |=> MEM_WE_O && MEM_WDATA_O == $past(p2_ff) ##1 !MEM_WE_O)
      else $error("data write missing");
   read_back_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      is_dread |=> MEM_RE_O ##1 rd_pend_ff)
      else $error("read not issued");
   font_keep_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      cmd_wr && db_s == CMD_FONT && !p1_ff[1] |=> $stable(FONT_SEL_O))
      else $error("font changed");
   auto_exit_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      cmd_wr && db_s == CMD_AUTO_RST |=> !AUTO_WR_O && !AUTO_RD_O)
      else $error("auto mode kept");
endmodule

/* File: testbench/glcd_mem_model.sv */
// display memory model standing behind the decoder's memory port
`timescale 1ns/10ps
module glcd_mem_model (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic re_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem_ff [0:255];
   logic [7:0] q_ff;
   logic vld_ff;
   // outside the valid cycle show the inverse so stale data cannot pass
   assign rdata_o = vld_ff ? q_ff : ~q_ff;
   initial begin
      q_ff = 8'h00;
      vld_ff = 1'b0;
   end
   always @(posedge clk_i) begin
      if (we_i) mem_ff[addr_i[7:0]] <= wdata_i;
      q_ff <= re_i ? mem_ff[addr_i[7:0]] : q_ff;
      vld_ff <= re_i;
   end
endmodule

/* File: testbench/glcd_decoder_tb_top.sv */
// self-checking bench of the graphic lcd command decoder
`timescale 1ns/10ps
module glcd_decoder_tb_top;
   import glcd_pkg::*;
   logic clk, rst, wr_n, rd_n, ce_n, cd, dual, oe, we, re;
   logic [7:0] db_i, db_o, rdata, st, v, wdata, ta, ga;
   logic [15:0] addr, th, gh;
   logic [6:0] col;
   logic [4:0] row, ofs;
   logic [2:0] cmb, ch, bt;
   logic [1:0] fs;
   logic lower, ext, ton, gon, con, cbl, awr, ard, rev, amv, oe_seen;
   logic [7:0] mset [4] = '{8'h80, 8'h89, 8'h83, 8'h8C};
   logic [7:0] dm [6] = '{8'h9F, 8'h94, 8'h93, 8'h92, 8'h98, 8'h90};
   int fail_count = 0;
   int checked = 0;
   glcd_decoder i_glcd_decoder (.CLK_I(clk), .RST_I(rst), .WR_N_I(wr_n), .RD_N_I(rd_n), .CE_N_I(ce_n),
      .CD_I(cd), .DB_I(db_i), .DB_O(db_o), .DB_OE_O(oe), .DUAL_SCAN_I(dual), .MEM_WE_O(we), .MEM_RE_O(re),
      .MEM_ADDR_O(addr), .MEM_WDATA_O(wdata), .MEM_RDATA_I(rdata), .CURSOR_COL_O(col), .CURSOR_ROW_O(row),
      .CURSOR_LOWER_O(lower), .CG_OFFSET_O(ofs), .TEXT_HOME_O(th), .TEXT_AREA_O(ta), .GFX_HOME_O(gh),
      .GFX_AREA_O(ga), .COMBINE_MODE_O(cmb), .EXT_EXTERNAL_CHARACTER_RAM_O(ext), .TEXT_ON_O(ton), .GFX_ON_O(gon),
      .CURSOR_ON_O(con), .CURSOR_BLINK_O(cbl), .CURSOR_HEIGHT_O(ch), .AUTO_WR_O(awr), .AUTO_RD_O(ard),
      .REVERSE_O(rev), .BLINK_TIME_O(bt), .AUTO_MOVE_O(amv), .FONT_SEL_O(fs));
   glcd_mem_model i_glcd_mem_model (.clk_i(clk), .we_i(we), .re_i(re), .addr_i(addr), .wdata_i(wdata),
      .rdata_o(rdata));
   // ------
   // host access tasks
   // ------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // strobes stay low 7 cycles, above the 5 cycles an auto read needs, so DB_O has settled
   task automatic strobe(input logic c, input logic w, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      cd <= c;
      db_i <= d;
      ce_n <= 1'b0;
      wr_n <= !w;
      rd_n <= w;
      repeat (7) @(posedge clk);
      q = db_o;
      oe_seen = oe;
      ce_n <= 1'b1;
      wr_n <= 1'b1;
      rd_n <= 1'b1;
      db_i <= ~d;
      repeat (4) @(posedge clk);
   endtask
   task automatic wr(input logic c, input logic [7:0] d);
      strobe(1'b1, 1'b0, 8'h00, st);
      // ready flags mean nothing in burst mode
      if (!awr && !ard) chk(16'(st[1:0]), 16'h3);
      strobe(c, 1'b1, d, v);
   endtask
   task automatic p2(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      wr(1'b0, a);
      wr(1'b0, b);
      wr(1'b1, c);
   endtask
   task automatic rdd(input logic [7:0] c, input logic [7:0] exp);
      wr(1'b1, c);
      strobe(1'b0, 1'b0, 8'h00, v);
      chk(16'(v), 16'(exp));
      chk(16'(oe_seen), 16'h1);
      chk(16'(oe), 16'h0);
   endtask
   task automatic complete_run();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ------
   // clock, watchdog and tests
   // ------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #5_000_000;
      fail_count++;
      complete_run();
   end
   initial begin
      rst = 1'b1; wr_n = 1'b1; rd_n = 1'b1; ce_n = 1'b1; cd = 1'b0; dual = 1'b0; db_i = 8'h00;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(16'(bt), 16'h2);
      chk(16'(fs), 16'h0);
      chk(16'(amv), 16'h0);
      p2(8'hCF, 8'hF3, CMD_CURSOR);
      chk(16'(col), 16'h4F);
      chk(16'(row), 16'h13);
      chk(16'(lower), 16'h0);
      dual <= 1'b1;
      repeat (6) @(posedge clk);
      chk(16'(lower), 16'h1);
      p2(8'hFF, 8'h00, CMD_OFFSET);
      chk(16'(ofs), 16'h1F);
      p2(8'h34, 8'h12, CMD_TXT_HOME);
      chk(th, 16'h1234);
      p2(8'h1E, 8'h00, CMD_TXT_AREA);
      chk(16'(ta), 16'h1E);
      p2(8'hCD, 8'hAB, CMD_GFX_HOME);
      chk(gh, 16'hABCD);
      p2(8'h28, 8'h00, CMD_GFX_AREA);
      chk(16'(ga), 16'h28);
      for (int i = 0; i < 4; i++) begin
         wr(1'b1, mset[i]);
         chk(16'(cmb), 16'(mset[i][2:0]));
         chk(16'(ext), 16'(mset[i][3]));
      end
      wr(1'b1, 8'h8A);
      chk(16'(cmb), 16'h4);
      for (int i = 0; i < 6; i++) begin
         wr(1'b1, dm[i]);
         chk(16'({gon, ton, con, cbl}), 16'(dm[i][3:0]));
      end
      for (int n = 0; n < 8; n++) begin
         wr(1'b1, {GRP_CURPAT, 3'(n)});
         chk(16'(ch), 16'(n));
      end
      p2(8'h10, 8'h00, CMD_ADDR);
      wr(1'b0, 8'hAA); wr(1'b1, 8'hC0);
      wr(1'b0, 8'h55); wr(1'b1, 8'hC2);
      wr(1'b0, 8'h77); wr(1'b1, 8'hC4);
      rdd(8'hC5, 8'h77);
      rdd(8'hC1, 8'h77);
      rdd(8'hC3, 8'h55);
      rdd(8'hC1, 8'h77);
      chk(16'({col, row}), 16'({7'h4F, 5'h13}));
      p2(8'h20, 8'h00, CMD_ADDR);
      wr(1'b1, CMD_AUTO_WR);
      chk(16'(awr), 16'h1);
      wr(1'b0, 8'h5A); wr(1'b0, 8'hA5);
      wr(1'b1, CMD_AUTO_RST);
      chk(16'(awr), 16'h0);
      p2(8'h20, 8'h00, CMD_ADDR);
      rdd(8'hC1, 8'h5A);
      rdd(8'hC1, 8'hA5);
      p2(8'h20, 8'h00, CMD_ADDR);
      wr(1'b1, CMD_AUTO_RD);
      chk(16'(ard), 16'h1);
      strobe(1'b0, 1'b0, 8'h00, v);
      chk(16'(v), 16'h5A);
      strobe(1'b0, 1'b0, 8'h00, v);
      chk(16'(v), 16'hA5);
      wr(1'b1, CMD_AUTO_RST);
      chk(16'(ard), 16'h0);
      p2(8'h30, 8'h00, CMD_ADDR);
      wr(1'b0, 8'h00); wr(1'b1, 8'hC4);
      wr(1'b1, 8'hFB); wr(1'b1, 8'hFF); wr(1'b1, 8'hF3);
      rdd(8'hC5, 8'h80);
      p2(8'h01, 8'hFF, CMD_REVERSE);
      chk(16'(rev), 16'h1);
      p2(8'hFE, 8'h01, CMD_REVERSE);
      chk(16'(rev), 16'h0);
      for (int b = 0; b < 8; b++) begin
         p2({5'h1F, 3'(b)}, 8'hAA, CMD_BLINK);
         chk(16'(bt), 16'(b));
      end
      p2(8'h01, 8'h00, CMD_AUTOMOVE);
      chk(16'(amv), 16'h1);
      p2(8'h02, 8'hFF, CMD_FONT);
      chk(16'(fs), 16'h2);
      p2(8'h01, 8'h00, CMD_FONT);
      chk(16'(fs), 16'h2);
      p2(8'h03, 8'h00, CMD_FONT);
      chk(16'(fs), 16'h3);
      complete_run();
   end
endmodule
